// ===== rtl/sbf_pkg.sv
// Constants shared by the serial bus status-flag logic.
// Assumes nothing beyond a SystemVerilog compiler.
package sbf_pkg;

  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int unsigned STAT_W       = 8;
  localparam int unsigned STAT_STOP    = 3;
  localparam int unsigned STAT_ARB_OVR = 2;
  localparam logic        FLAG_RESET   = 1'b0;
  localparam logic [7:0]  STAT_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Framing and crossing
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 8;
  localparam int unsigned SYNC_STAGES  = 2;

endpackage : sbf_pkg

// ===== rtl/sbf_link_if.sv
// Carrier between the link-clock logic and the core-clock flag logic.
// Assumes the core holds fmt_sync steady while frames run.
`timescale 1ns/100ps
`default_nettype none

interface sbf_link_if;
  logic rise_tgl;
  logic final_tgl;
  logic sda_bit;
  logic fmt_sync;

  modport link (
    output rise_tgl,
    output final_tgl,
    output sda_bit,
    input  fmt_sync
  );

  modport core (
    input  rise_tgl,
    input  final_tgl,
    input  sda_bit,
    output fmt_sync
  );
endinterface : sbf_link_if

`default_nettype wire

// ===== rtl/sbf_link_edge.sv
// Link-clock side: samples SDA at each rise of SCL and counts frame bits in synchronous format.
// Assumes SCL is the link clock and may stand still between frames.
`timescale 1ns/100ps
`default_nettype none

module sbf_link_edge
  import sbf_pkg::*;
#(
  parameter int unsigned BITS = FRAME_BITS
) (
  // Link clock and reset
  input  wire logic   scl,
  input  wire logic   rst,
  // Bus pin
  input  wire logic   sda_pin,
  // Towards the core
  sbf_link_if.link    lnk
);

  localparam int unsigned CW = (BITS > 1) ? $clog2(BITS) : 1;

  if (BITS < 2 || BITS > 256) begin : g_bad_bits
    $error("sbf_link_edge: BITS must lie in 2..256");
  end

  typedef struct packed {
    logic [CW-1:0] bit_cnt;
    logic          rise_tgl;
    logic          final_tgl;
    logic          sda_cap;
    logic          mode_s1;
    logic          mode_s2;
  } sbf_edge_t;

  sbf_edge_t st;
  sbf_edge_t next_st;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.mode_s1  = lnk.fmt_sync;
    next_st.mode_s2  = st.mode_s1;
    // Every rise toggles rise_tgl and hands the sampled bit over as a level
    next_st.sda_cap  = sda_pin;
    next_st.rise_tgl = ~st.rise_tgl;
    if (!st.mode_s2) begin
      next_st.bit_cnt = '0;
    end else if (st.bit_cnt == CW'(BITS - 1)) begin
      next_st.bit_cnt   = '0;
      next_st.final_tgl = ~st.final_tgl;
    end else begin
      next_st.bit_cnt = st.bit_cnt + CW'(1);
    end
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lnk.rise_tgl  = st.rise_tgl;
  assign lnk.final_tgl = st.final_tgl;
  assign lnk.sda_bit   = st.sda_cap;

endmodule : sbf_link_edge

`default_nettype wire

// ===== rtl/sbf_flags.sv
// Arbitration-lost / overrun flag and stop-detection flag of a two-wire
// serial interface running in bus format or clocked synchronous format.
// Assumes software reads and writes the status byte through the strobes
// below, and that the transfer engine supplies the mode levels and the
// level it drives internally on SDA.
// SCL clocks a small link part that samples SDA at each rise. Its events
// reach the core clock as toggles through two flip-flops. The sampled bit
// is read only once its toggle has arrived, when it has stood still a while.
// SCL high and low phases need at least four core cycles for start and stop
// to be seen. The mode levels must stand for about three core cycles after
// each rise of SCL.
// Both flags clear only on a write of 0 that follows a read which saw them
// at 1; a set in the same cycle as such a write wins.
`timescale 1ns/100ps
`default_nettype none

module sbf_flags
  import sbf_pkg::*;
#(
  parameter int unsigned BITS = FRAME_BITS
) (
  // Core clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Bus pins; scl also clocks the link logic
  input  wire logic              scl,
  input  wire logic              sda_pin,
  // Mode levels from the transfer engine
  input  wire logic              master_mode,
  input  wire logic              tx_mode,
  input  wire logic              fmt_sync,
  input  wire logic              sda_int,
  input  wire logic              rx_data_full_flag,
  // Software access to the status byte
  input  wire logic              stat_rd,
  input  wire logic              stat_wr,
  input  wire logic [STAT_W-1:0] stat_wdata,
  // Flags
  output logic [STAT_W-1:0]      stat_rdata,
  output logic                   arb_lost_overrun_flag,
  output logic                   stop_flag
);

  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_d;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_d;
    logic              rise_s1;
    logic              rise_s2;
    logic              rise_d;
    logic              fin_s1;
    logic              fin_s2;
    logic              fin_d;
    logic              in_frame;
    logic              arb;
    logic              stop;
    logic              arb_armed;
    logic              stop_armed;
    logic [STAT_W-1:0] rdata;
  } sbf_core_t;

  sbf_core_t st;
  sbf_core_t next_st;

  sbf_link_if lnk ();

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (BITS < 2 || BITS > 256) begin : g_bad_bits
    $error("sbf_flags: BITS must lie in 2..256");
  end

  // ---------------------------------------------------------------
  // Link-clock side
  // ---------------------------------------------------------------
  // SCL clocks this part; it hands each rise and, in synchronous format, each final
  // frame bit over by toggle, and the bit it sampled as a level
  sbf_link_edge #(
    .BITS (BITS)
  ) u_edge (
    .scl     (scl),
    .rst     (rst),
    .sda_pin (sda_pin),
    .lnk     (lnk.link)
  );

  assign lnk.fmt_sync = fmt_sync;

  // ---------------------------------------------------------------
  // Bus events seen in the core domain
  // ---------------------------------------------------------------
  logic start_det;
  logic stop_det;
  logic rise_evt;
  logic final_evt;
  logic set_arb;
  logic set_stop;
  logic clr_arb;
  logic clr_stop;
  logic bit_differs;

  always_comb begin
    // SDA moving while SCL stays high marks start and stop
    start_det = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
    stop_det  = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
    // A toggle from the link side becomes a one-cycle event pulse
    rise_evt  = st.rise_s2 ^ st.rise_d;
    final_evt = st.fin_s2 ^ st.fin_d;
    // The link bit stands from one rise of SCL to the next, so it is steady
    // by the time its synchronised toggle shows up here
    bit_differs = lnk.sda_bit != sda_int;

    set_arb = 1'b0;
    if (!fmt_sync && master_mode && tx_mode && rise_evt
        && bit_differs) begin
      set_arb = 1'b1;
    end
    if (!fmt_sync && master_mode && start_det && sda_int) begin
      set_arb = 1'b1;
    end
    if (fmt_sync && final_evt && rx_data_full_flag) begin
      set_arb = 1'b1;
    end

    set_stop = !fmt_sync && stop_det && st.in_frame;

    // Write of 0 clears only after a read that saw the flag at 1
    clr_arb  = stat_wr && !stat_wdata[STAT_ARB_OVR] && st.arb_armed;
    clr_stop = stat_wr && !stat_wdata[STAT_STOP] && st.stop_armed;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st         = st;
    // Two flip-flops stand between every pin or link toggle and the logic
    next_st.scl_s1  = scl;
    next_st.scl_s2  = st.scl_s1;
    next_st.scl_d   = st.scl_s2;
    next_st.sda_s1  = sda_pin;
    next_st.sda_s2  = st.sda_s1;
    next_st.sda_d   = st.sda_s2;
    next_st.rise_s1 = lnk.rise_tgl;
    next_st.rise_s2 = st.rise_s1;
    next_st.rise_d  = st.rise_s2;
    next_st.fin_s1  = lnk.final_tgl;
    next_st.fin_s2  = st.fin_s1;
    next_st.fin_d   = st.fin_s2;

    // A frame is under way from a start until the next stop
    if (start_det) begin
      next_st.in_frame = 1'b1;
    end else if (stop_det) begin
      next_st.in_frame = 1'b0;
    end

    // Set wins over a clear in the same cycle
    if (set_arb) begin
      next_st.arb = 1'b1;
    end else if (clr_arb) begin
      next_st.arb = 1'b0;
    end
    if (set_stop) begin
      next_st.stop = 1'b1;
    end else if (clr_stop) begin
      next_st.stop = 1'b0;
    end

    // Arming follows a read of 1; any write consumes it
    // A read and a write in one cycle: the write uses the old arming
    if (stat_wr) begin
      next_st.arb_armed  = 1'b0;
      next_st.stop_armed = 1'b0;
    end else if (stat_rd) begin
      next_st.arb_armed  = st.arb;
      next_st.stop_armed = st.stop;
    end

    // Read data follows the flags; spare bits read as 0
    next_st.rdata               = STAT_RESET;
    next_st.rdata[STAT_ARB_OVR] = next_st.arb;
    next_st.rdata[STAT_STOP]    = next_st.stop;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st       <= '0;
      st.arb   <= FLAG_RESET;
      st.stop  <= FLAG_RESET;
      st.rdata <= STAT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All outputs are flop outputs; nothing combinational leaves the block
  assign stat_rdata            = st.rdata;
  assign arb_lost_overrun_flag = st.arb;
  assign stop_flag             = st.stop;

endmodule : sbf_flags

`default_nettype wire

// ===== testbench/sbf_bus_peer.sv
// Far-side bus party: drives SCL and releases or pulls SDA.
// Assumes the bench ANDs its SDA with the device's own level.
`timescale 1ns/100ps
`default_nettype none
module sbf_bus_peer (
  // Bus levels
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start;
    sda = 1'b1;
    #500 scl = 1'b1;
    #500 sda = 1'b0;
    #500 scl = 1'b0;
  endtask : start
  task automatic stop;
    sda = 1'b0;
    #500 scl = 1'b1;
    #500 sda = 1'b1;
    #500;
  endtask : stop
  // SCL stands low after each bit
  task automatic bit_out(input logic v, input realtime h);
    sda = v;
    #h scl = 1'b1;
    #h scl = 1'b0;
  endtask : bit_out
endmodule : sbf_bus_peer
`default_nettype wire

// ===== testbench/sbf_flags_properties.sv
// Checker for the status flags.
// Assumes one core clock and the active-high reset.
`timescale 1ns/100ps
`default_nettype none
module sbf_flags_properties
  import sbf_pkg::*;
(
  // Clock, reset, modes
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              master_mode,
  input wire logic              fmt_sync,
  // Status access
  input wire logic              stat_rd,
  input wire logic              stat_wr,
  input wire logic [STAT_W-1:0] stat_wdata,
  input wire logic [STAT_W-1:0] stat_rdata,
  input wire logic              arb_lost_overrun_flag,
  input wire logic              stop_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_one;
    stat_rd && arb_lost_overrun_flag;
  endsequence
  sequence wr_zero;
    stat_wr && !stat_rd && !stat_wdata[STAT_ARB_OVR] && !master_mode && !fmt_sync;
  endsequence
  a_arb_bit_map: assert property (arb_lost_overrun_flag == stat_rdata[STAT_ARB_OVR])
    else $error("arb bit wrong");
  a_stop_bit_map: assert property (stop_flag == stat_rdata[STAT_STOP])
    else $error("stop bit wrong");
  a_spare_bits_zero: assert property ((stat_rdata & 8'hf3) == 8'h00)
    else $error("spare bits set");
  a_arb_holds: assert property (arb_lost_overrun_flag && !stat_wr |=> arb_lost_overrun_flag)
    else $error("arb dropped");
  a_stop_holds: assert property (stop_flag && !stat_wr |=> stop_flag)
    else $error("stop dropped");
  a_arb_clears: assert property (rd_one ##2 wr_zero |=> !arb_lost_overrun_flag)
    else $error("arb not cleared");
  a_arb_cause: assert property ($rose(arb_lost_overrun_flag) |-> $past(master_mode) || $past(fmt_sync))
    else $error("arb set idle");
  a_stop_cause: assert property ($rose(stop_flag) |-> !$past(fmt_sync))
    else $error("stop set in sync");
endmodule : sbf_flags_properties
bind sbf_flags sbf_flags_properties u_props (.clk(clk), .rst(rst),
  .master_mode(master_mode), .fmt_sync(fmt_sync), .stat_rd(stat_rd),
  .stat_wr(stat_wr), .stat_wdata(stat_wdata), .stat_rdata(stat_rdata),
  .arb_lost_overrun_flag(arb_lost_overrun_flag), .stop_flag(stop_flag));
`default_nettype wire

// ===== testbench/serial_bus_arb_overrun_flags_bench.sv
// Self-checking bench for the status flags.
// Assumes the peer model drives SCL and the far side of SDA.
`timescale 1ns/100ps
`default_nettype none
module serial_bus_arb_overrun_flags_bench;
  import sbf_pkg::*;
  localparam int N = 8;
  logic              clk, rst, scl, sda_peer, sda_pin, master_mode, tx_mode;
  logic              fmt_sync, sda_int, rx_data_full_flag, stat_rd, stat_wr;
  logic              arb_lost_overrun_flag, stop_flag;
  logic [STAT_W-1:0] stat_wdata, stat_rdata;
  logic [15:0]       lf;
  logic [7:0]        d, p;
  int                failures, checked;
  assign sda_pin = sda_peer & sda_int;
  sbf_flags #(.BITS(N)) dut (.clk(clk), .rst(rst), .scl(scl), .sda_pin(sda_pin),
    .master_mode(master_mode), .tx_mode(tx_mode), .fmt_sync(fmt_sync),
    .sda_int(sda_int), .rx_data_full_flag(rx_data_full_flag), .stat_rd(stat_rd),
    .stat_wr(stat_wr), .stat_wdata(stat_wdata), .stat_rdata(stat_rdata),
    .arb_lost_overrun_flag(arb_lost_overrun_flag), .stop_flag(stop_flag));
  sbf_bus_peer peer (.scl(scl), .sda(sda_peer));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] lost(input logic [7:0] a, b, input logic t);
    return {5'h00, t & (|(a & ~b)), 2'h0};
  endfunction : lost
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic chk(input string n, input logic [7:0] e);
    #10;
    checked++;
    if (stat_rdata !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, stat_rdata);
    end
  endtask : chk
  task automatic acc(input logic r, input logic w, input logic [7:0] v);
    @(posedge clk);
    stat_rd <= r;
    stat_wr <= w;
    stat_wdata <= v;
    @(posedge clk);
    stat_rd <= 1'b0;
    stat_wr <= 1'b0;
  endtask : acc
  task automatic clear;
    @(posedge clk);
    master_mode <= 1'b0;
    sda_int <= 1'b1;
    acc(1'b1, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h00);
    wt(2);
  endtask : clear
  task automatic conclude;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    {rst, sda_int} = 2'h3;
    {master_mode, tx_mode, fmt_sync, rx_data_full_flag, stat_rd, stat_wr} = 6'h00;
    stat_wdata = 8'h00;
    lf = 16'h6919;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk("reset", 8'h00);
    peer.start();
    peer.stop();
    wt(8);
    chk("stop", 8'h08);
    acc(1'b0, 1'b1, 8'h00);
    chk("blind write", 8'h08);
    acc(1'b1, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'hff);
    chk("write one", 8'h08);
    clear();
    chk("stop clear", 8'h00);
    peer.start();
    wt(8);
    chk("slave start", 8'h00);
    @(posedge clk) master_mode <= 1'b1;
    #20 peer.start();
    wt(8);
    chk("start lost", 8'h04);
    acc(1'b0, 1'b1, 8'h00);
    chk("blind write", 8'h04);
    clear();
    chk("arb clear", 8'h00);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      d = (i == 1) ? 8'hff : lf[7:0];
      p = (i == 0) ? d : (i == 1) ? 8'h00 : lf[15:8];
      @(posedge clk);
      master_mode <= 1'b1;
      tx_mode <= (i != 1);
      for (int b = 7; b >= 0; b--) begin
        @(posedge clk) sda_int <= d[b];
        #20 peer.bit_out(p[b], 300); // Off the core edge, so no false start or stop
      end
      wt(8);
      chk("arb data", lost(d, p, i != 1));
      clear();
    end
    @(posedge clk) fmt_sync <= 1'b1;
    #20 repeat (N + 3) peer.bit_out(1'b1, 7.5);
    wt(8);
    chk("no overrun", 8'h00);
    @(posedge clk) rx_data_full_flag <= 1'b1;
    repeat (N - 3) peer.bit_out(1'b1, 7.5);
    wt(8);
    chk("early bit", 8'h00);
    repeat (3) peer.bit_out(1'b1, 7.5);
    wt(8);
    chk("overrun", 8'h04);
    conclude();
  end
endmodule : serial_bus_arb_overrun_flags_bench
`default_nettype wire
